//--- hdl/reset_sync.sv
// Two-flop reset release synchroniser.
`timescale 1ns/1ns
module reset_sync
(
	// Clock and raw reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Synchronised reset.
	output logic rst_n_o
);
	logic [1:0] sync_reg;
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			sync_reg <= 2'h0;
		else
			sync_reg <= {sync_reg[0], 1'b1};
	end
	assign rst_n_o = sync_reg[1];
endmodule : reset_sync

//--- hdl/strap_capture.sv
// Reset strap capture and the control decode it steers.
// Operation
// - In reset, float address pins, capture bits 24:0; code captures on the second cycle after synchronous release
// - Clock-set strap overrides fuse, never above maximum
// - Bits 20:17 captured, readable, otherwise unused
// - Wait bit one samples wait on cs0
// - Wait bit zero, async mode ignores wait
// - Sync mode ignores wait, uses counters
// - USB select one makes both clocks internally
// - USB select zero takes clocks from pins 0/1
// - Arbiter bit zero relies on external arbiter
// - Arbiter bit one enables internal arbiter
// - Flash width from wide and narrow bits
`timescale 1ns/1ns
`include "strap_defs.svh"
module strap_capture
(
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Expansion address pins, shared with strap sensing.
	input wire logic [24:0] exp_address_pins_i,
	input wire logic [24:0] exp_address_drv_i,
	output logic [24:0] exp_address_pins_o,
	output logic [24:0] exp_address_pins_oe_o,
	// Fused core speed limit.
	input wire logic [2:0] fuse_clk_max_i,
	// Chip select 0 wait handling.
	input wire logic slave_wait_in_i,
	input wire logic cs0_cycle_i,
	input wire logic cs0_sync_mode_i,
	input wire logic sync_wait_i,
	output logic cs0_wait_o,
	// Clock, arbitration and flash width controls.
	output logic [2:0] core_clk_sel_o,
	output logic usb_clk_internal_o,
	output logic usb_dev_clk_from_pin_o,
	output logic usb_host_clk_from_pin_o,
	output logic internal_arb_en_o,
	output logic [1:0] flash_width_o,
	// Captured configuration readback.
	output logic [24:0] cfg_readback_o,
	output logic [3:0] board_rev_o,
	output logic cfg_valid_o
);
	typedef struct packed {
		strap_pkg::phase_e phase;
		logic [24:0] cfg;
		strap_pkg::strap_ctrl_s ctrl;
		logic cs0_wait;
		logic valid;
		logic usb_from_pin;
		logic [24:0] pin_out;
		logic [24:0] pin_oe;
	} state_s;

	logic rst_sync_n;
	state_s st_reg;
	state_s st_next;
	logic [2:0] clk_req;
	logic [1:0] width;

	reset_sync reset_sync_inst
	(
		.clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.rst_n_o(rst_sync_n)
	);

	always_comb
	begin
		st_next = st_reg;
		clk_req = st_reg.cfg[`CLKSET_HI:`CLKSET_LO];
		width = `WIDTH_RSVD;
		// Address pins stay inputs until the straps are held, so sensing is undisturbed.
		st_next.pin_out = exp_address_drv_i;
		st_next.pin_oe = (st_reg.phase == strap_pkg::ST_RUN) ? 25'h1FFFFFF : 25'h0;
		case ({st_reg.cfg[`WIDE_FLASH_BIT], st_reg.cfg[`NARROW_FLASH_BIT]})
			2'h0: width = `WIDTH_16;
			2'h1: width = `WIDTH_8;
			2'h3: width = `WIDTH_32;
			default: width = `WIDTH_RSVD;
		endcase
		case (st_reg.phase)
			strap_pkg::ST_RESET:
			begin
				st_next.phase = strap_pkg::ST_CAPTURE;
			end
			strap_pkg::ST_CAPTURE:
			begin
				// Second cycle after synchronous release: pins are still inputs.
				st_next.cfg = exp_address_pins_i;
				st_next.phase = strap_pkg::ST_RUN;
				st_next.valid = 1'b1;
			end
			strap_pkg::ST_RUN:
			begin
				st_next.ctrl.core_clk_sel = (clk_req > fuse_clk_max_i) ? fuse_clk_max_i : clk_req;
				st_next.ctrl.board_rev = st_reg.cfg[`BOARD_HI:`BOARD_LO];
				st_next.ctrl.wait_sample_cs0 = st_reg.cfg[`WAIT_CS0_BIT];
				st_next.ctrl.usb_clk_internal = st_reg.cfg[`USB_CLK_BIT];
				st_next.usb_from_pin = ~st_reg.cfg[`USB_CLK_BIT];
				st_next.ctrl.flash_width = width;
				st_next.ctrl.exp_arbiter_sel = st_reg.cfg[`ARB_BIT];
				if (cs0_sync_mode_i)
					st_next.cs0_wait = cs0_cycle_i & sync_wait_i;
				else if (st_reg.cfg[`WAIT_CS0_BIT])
					st_next.cs0_wait = cs0_cycle_i & ~slave_wait_in_i;
				else
					st_next.cs0_wait = 1'b0;
			end
			default:
			begin
				st_next.phase = strap_pkg::ST_RESET;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			st_reg.phase <= strap_pkg::ST_RESET;
			st_reg.cfg <= `CFG_RESET;
			st_reg.ctrl <= '0;
			st_reg.cs0_wait <= 1'b0;
			st_reg.valid <= 1'b0;
			st_reg.usb_from_pin <= 1'b0;
			st_reg.pin_out <= 25'h0;
			st_reg.pin_oe <= 25'h0;
		end
		else
			st_reg <= st_next;
	end

	assign exp_address_pins_o = st_reg.pin_out;
	assign exp_address_pins_oe_o = st_reg.pin_oe;
	assign cs0_wait_o = st_reg.cs0_wait;
	assign core_clk_sel_o = st_reg.ctrl.core_clk_sel;
	assign usb_clk_internal_o = st_reg.ctrl.usb_clk_internal;
	assign usb_dev_clk_from_pin_o = st_reg.usb_from_pin;
	assign usb_host_clk_from_pin_o = st_reg.usb_from_pin;
	assign internal_arb_en_o = st_reg.ctrl.exp_arbiter_sel;
	assign flash_width_o = st_reg.ctrl.flash_width;
	assign cfg_readback_o = st_reg.cfg;
	assign board_rev_o = st_reg.ctrl.board_rev;
	assign cfg_valid_o = st_reg.valid;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_sync_n);

	sequence captured_s;
		$rose(cfg_valid_o);
	endsequence

	capture_pins_a: assert property (captured_s |-> cfg_readback_o == $past(exp_address_pins_i))
		else $error("Strap capture mismatch.");
	oe_off_a: assert property (!cfg_valid_o |-> exp_address_pins_oe_o == 25'h0)
		else $error("Address pins driven before capture.");
	clk_cap_a: assert property (cfg_valid_o ##1 cfg_valid_o |->
		core_clk_sel_o <= $past(fuse_clk_max_i))
		else $error("Core speed above fused maximum.");
	board_rev_a: assert property (captured_s ##1 1'b1 |=> board_rev_o == cfg_readback_o[20:17])
		else $error("Board bits not readable.");
	wait_sample_a: assert property (cfg_valid_o && !cs0_sync_mode_i && cfg_readback_o[10] &&
		cs0_cycle_i && !slave_wait_in_i |=> cs0_wait_o)
		else $error("Wait not sampled on cs0.");
	wait_ignore_a: assert property (cfg_valid_o && !cs0_sync_mode_i &&
		!cfg_readback_o[10] |=> !cs0_wait_o)
		else $error("Wait not ignored on cs0.");
	sync_wait_a: assert property (cfg_valid_o && cs0_sync_mode_i |=>
		cs0_wait_o == $past(cs0_cycle_i && sync_wait_i))
		else $error("Sync wait source wrong.");
	arb_sel_a: assert property (captured_s ##1 1'b1 |=>
		internal_arb_en_o == cfg_readback_o[6])
		else $error("Arbiter select wrong.");
	usb_sel_a: assert property (captured_s ##1 1'b1 |=>
		usb_dev_clk_from_pin_o == !cfg_readback_o[8])
		else $error("USB clock source wrong.");
	width_a: assert property (captured_s ##1 1'b1 ##1
		(cfg_readback_o[7:0] & 8'h81) == 8'h01 |-> flash_width_o == 2'h1)
		else $error("Flash width decode wrong.");

	// Decoded controls settle one cycle after the capture flag rises.
	sequence settled_s;
		captured_s ##1 1'b1;
	endsequence

	cfg_default_a: assert property (!cfg_valid_o |-> cfg_readback_o == `CFG_RESET)
		else $error("Configuration not all ones before capture.");
	valid_hold_a: assert property (cfg_valid_o |=> cfg_valid_o)
		else $error("Capture flag dropped without reset.");
	cfg_hold_a: assert property (cfg_valid_o ##1 cfg_valid_o |-> $stable(cfg_readback_o))
		else $error("Captured configuration changed.");
	oe_release_a: assert property (captured_s |=> exp_address_pins_oe_o == 25'h1FFFFFF)
		else $error("Address pins not released to drive.");
	pin_drive_a: assert property (cfg_valid_o |->
		exp_address_pins_o == $past(exp_address_drv_i))
		else $error("Address drive value wrong.");
	clk_follow_a: assert property (settled_s ##0 cfg_readback_o[23:21] <= fuse_clk_max_i |=>
		core_clk_sel_o == cfg_readback_o[23:21])
		else $error("Clock-set strap not applied.");
	clk_limit_a: assert property (settled_s ##0 cfg_readback_o[23:21] > fuse_clk_max_i |=>
		core_clk_sel_o == $past(fuse_clk_max_i))
		else $error("Core speed not held at fused maximum.");
	usb_host_a: assert property (settled_s |=> usb_host_clk_from_pin_o == !cfg_readback_o[8])
		else $error("USB host clock source wrong.");
	usb_internal_a: assert property (settled_s |=> usb_clk_internal_o == cfg_readback_o[8])
		else $error("USB internal clock select wrong.");
	wait_idle_a: assert property (cfg_valid_o && !cs0_sync_mode_i && !cs0_cycle_i |=>
		!cs0_wait_o)
		else $error("Wait raised outside a cs0 cycle.");
	wait_release_a: assert property (cfg_valid_o && !cs0_sync_mode_i && slave_wait_in_i |=>
		!cs0_wait_o)
		else $error("Wait raised while wait input idle.");
	width_16_a: assert property (settled_s ##1 (cfg_readback_o[7:0] & 8'h81) == 8'h00 |->
		flash_width_o == `WIDTH_16)
		else $error("Flash width decode wrong.");
	width_32_a: assert property (settled_s ##1 (cfg_readback_o[7:0] & 8'h81) == 8'h81 |->
		flash_width_o == `WIDTH_32)
		else $error("Flash width decode wrong.");
	width_rsvd_a: assert property (settled_s ##1 (cfg_readback_o[7:0] & 8'h81) == 8'h80 |->
		flash_width_o == `WIDTH_RSVD)
		else $error("Flash width decode wrong.");
endmodule : strap_capture

//--- hdl/strap_defs.svh
// Strap bit positions, defaults and control constants for the strap capture block.
`ifndef STRAP_DEFS_SVH
`define STRAP_DEFS_SVH
`define CFG_WIDTH 25
`define CFG_RESET 25'h1FFFFFF
`define CLKSET_HI 23
`define CLKSET_LO 21
`define BOARD_HI 20
`define BOARD_LO 17
`define WAIT_CS0_BIT 10
`define USB_CLK_BIT 8
`define WIDE_FLASH_BIT 7
`define ARB_BIT 6
`define NARROW_FLASH_BIT 0
`define WIDTH_16 2'h0
`define WIDTH_8 2'h1
`define WIDTH_32 2'h2
`define WIDTH_RSVD 2'h3
`endif

//--- hdl/strap_pkg.sv
// Types shared by the strap capture block.
package strap_pkg;
	typedef enum logic [2:0] {
		ST_RESET = 3'h1,
		ST_CAPTURE = 3'h2,
		ST_RUN = 3'h4
	} phase_e;
	typedef struct packed {
		logic [2:0] core_clk_sel;
		logic [3:0] board_rev;
		logic wait_sample_cs0;
		logic usb_clk_internal;
		logic [1:0] flash_width;
		logic exp_arbiter_sel;
	} strap_ctrl_s;
endpackage : strap_pkg

//--- test/strap_board.sv
// Board strap resistor model on the expansion address pins.
`timescale 1ns/1ns
module strap_board
(
	// Fitted pull-downs and device drive.
	input wire logic [24:0] pull_dn_i,
	input wire logic [24:0] drv_i,
	input wire logic [24:0] oe_i,
	// Resolved pin levels.
	output logic [24:0] pins_o
);
	// A pin the device does not drive rests high unless a pull-down is fitted.
	assign pins_o = (oe_i & drv_i) | (~oe_i & ~pull_dn_i);
endmodule : strap_board

//--- test/strap_capture_tb.sv
// Self-checking bench for the strap capture block.
`timescale 1ns/1ns
`include "strap_defs.svh"
module strap_capture_tb;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [24:0] pull_dn = 25'h0000000;
	logic [24:0] drv = 25'h0000000;
	logic [24:0] pins, pin_drv, oe, cfg;
	logic [2:0] fuse = 3'h5;
	logic swait_n = 1'b1;
	logic cyc = 1'b0;
	logic sync = 1'b0;
	logic swt = 1'b0;
	logic wt, usb_int, dev_pin, host_pin, arb, valid;
	logic [2:0] clk_sel;
	logic [1:0] width;
	logic [3:0] rev;
	int n_mismatch = 0;
	int num_checks = 0;
	int cycles = 0;
	initial forever #5 sys_clk_i = ~sys_clk_i;
	strap_board strap_board_inst (.pull_dn_i(pull_dn), .drv_i(pin_drv), .oe_i(oe), .pins_o(pins));
	strap_capture strap_capture_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.exp_address_pins_i(pins), .exp_address_drv_i(drv), .exp_address_pins_o(pin_drv),
		.exp_address_pins_oe_o(oe), .fuse_clk_max_i(fuse), .slave_wait_in_i(swait_n),
		.cs0_cycle_i(cyc), .cs0_sync_mode_i(sync), .sync_wait_i(swt), .cs0_wait_o(wt),
		.core_clk_sel_o(clk_sel), .usb_clk_internal_o(usb_int),
		.usb_dev_clk_from_pin_o(dev_pin), .usb_host_clk_from_pin_o(host_pin),
		.internal_arb_en_o(arb), .flash_width_o(width), .cfg_readback_o(cfg),
		.board_rev_o(rev), .cfg_valid_o(valid));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [24:0] got, input logic [24:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Resets with a given pull-down fitting and waits until the pins are driven.
	task automatic boot(input logic [24:0] m);
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		pull_dn <= m;
		repeat (6) @(posedge sys_clk_i);
		#1;
		chk(oe, 25'h0000000);
		chk(cfg, `CFG_RESET);
		@(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (10) @(posedge sys_clk_i);
		#1;
		chk(valid, 1'b1);
	endtask : boot
	task automatic wchk(input logic n, c, s, w, e);
		@(posedge sys_clk_i);
		{swait_n, cyc, sync, swt} <= {n, c, s, w};
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk(wt, e);
	endtask : wchk
	task automatic t_default();
		boot(25'h0000000);
		chk(cfg, `CFG_RESET);
		chk(clk_sel, 3'h5);
		chk(rev, 4'hF);
		chk({usb_int, dev_pin, host_pin}, 3'h4);
		chk(arb, 1'b1);
		chk(width, `WIDTH_32);
		chk(oe, 25'h1FFFFFF);
		@(posedge sys_clk_i);
		drv <= 25'h0ABCDEF;
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk(pins, 25'h0ABCDEF);
		chk(cfg, `CFG_RESET);
		wchk(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		wchk(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		wchk(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		wchk(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
		$display("test default straps done");
	endtask : t_default
	task automatic t_pulls();
		boot(25'h0AA15C0);
		chk(cfg, 25'h155EA3F);
		chk(clk_sel, 3'h2);
		chk(rev, 4'hA);
		chk({usb_int, dev_pin, host_pin}, 3'h3);
		chk(arb, 1'b0);
		chk(width, `WIDTH_8);
		wchk(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		wchk(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
		$display("test pulled straps done");
	endtask : t_pulls
	task automatic t_width();
		logic [24:0] m [2] = '{25'h0000081, 25'h0000001};
		logic [1:0] e [2] = '{`WIDTH_16, `WIDTH_RSVD};
		for (int i = 0; i < 2; i++)
		begin
			boot(m[i]);
			chk(width, e[i]);
		end
		$display("test flash width done");
	endtask : t_width
	always @(posedge sys_clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 500)
		begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial
	begin
		t_default();
		t_pulls();
		t_width();
		give_verdict();
	end
endmodule : strap_capture_tb
